// *** src/sdram_timing_pkg.sv ***
// sdram_timing_pkg: constants and types for the sdram command timing core
// Functional notes
// - column commands may come every clock; device accepts them at that rate.
// - read byte mask floats that output byte two clocks later.
// - write byte mask blocks that input byte in the same clock.
// - precharge during read floats outputs 3 clocks later at latency 3, 2 at 2.
// - clock enable low suspends clock or enters power-down after 1 clock.
// - clock enable high resumes clock or leaves power-down after 1 clock.
// - deep power down ends on clock enable high; array contents are lost.
package sdram_timing_pkg;
   localparam int DATA_W = 32;
   localparam int MASK_W = 4;
   localparam int BANK_N = 4;
   localparam int ROW_W = 13;
   localparam int COL_W = 9;
   localparam int AP_BIT = 10;
   localparam int CL_LSB = 4;
   localparam logic [2:0] CL3_CODE = 3'h3;
   localparam logic CL3_RST = 1'b1;
   localparam logic [3:0] BLEN_M1_RST = 4'h0;

   typedef enum logic [2:0] {
      CMD_MRS = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
      CMD_WR = 3'h4, CMD_RD = 3'h5, CMD_BST = 3'h6, CMD_NOP = 3'h7
   } cmd_type;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00, ST_PDOWN = 2'b01, ST_SELFREF = 2'b11, ST_DEEP = 2'b10
   } pwr_type;

   typedef struct packed {
      logic csN;
      logic rasN;
      logic casN;
      logic weN;
      logic [1:0] ba;
      logic [ROW_W-1:0] addr;
   } cmd_pins_type;

   typedef struct packed {
      logic [1:0] bank;
      logic [ROW_W-1:0] row;
      logic [COL_W-1:0] col;
   } arr_addr_type;
endpackage

// *** src/sdram_timing_core.sv ***
// sdram_timing_core: command, burst, mask and clock-enable timing of the sdram device
`timescale 1ns/10ps
`default_nettype none
module sdram_timing_core
   import sdram_timing_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic cke,
   input wire cmd_pins_type pins,
   input wire logic [MASK_W-1:0] dqm,
   input wire logic [DATA_W-1:0] dqIn,
   input wire logic [DATA_W-1:0] rdData,
   output logic [DATA_W-1:0] dqOut_q,
   output logic [MASK_W-1:0] dqOe_q,
   output var arr_addr_type arrAddr_q,
   output logic arrRd_q,
   output logic arrWr_q,
   output logic [MASK_W-1:0] arrByteEn_q,
   output logic [DATA_W-1:0] arrWrData_q,
   output logic arrRefresh_q,
   output logic arrClear_q,
   output var pwr_type pwr_q
);
   function automatic cmd_type cmdOf(input cmd_pins_type p);
      return p.csN ? CMD_NOP : cmd_type'({p.rasN, p.casN, p.weN});
   endfunction

   // pins share clk_sys with the controller, so they are sampled without synchronisers
   cmd_type cmd;
   logic actv;
   logic clkOn_q, clkOn_d, rdBurst_q, rdBurst_d, wrBurst_q, wrBurst_d, ap_q, ap_d;
   logic cl3_q, cl3_d;
   logic [3:0] cnt_q, cnt_d, blenM1_q, blenM1_d;
   logic [COL_W-1:0] col_q, col_d;
   logic [1:0] bank_q, bank_d;
   logic [BANK_N-1:0] bankOpen_q, bankOpen_d;
   logic [ROW_W-1:0] openRow_q [BANK_N];
   logic [ROW_W-1:0] openRow_d [BANK_N];
   pwr_type pwr_d;
   arr_addr_type arrAddr_d;
   logic arrRd_d, arrWr_d, arrRefresh_d, arrClear_d;
   logic [MASK_W-1:0] arrByteEn_d, dqOe_d, dqmD1_q, dqmD1_d;
   logic [DATA_W-1:0] arrWrData_d, dqOut_d, p0Data_q, p0Data_d;
   logic p0Val_q, p0Val_d;

   assign cmd = cmdOf(pins);
   // commands count only on edges whose previous cke was high
   assign actv = clkOn_q && (pwr_q == ST_RUN);

   always_comb begin
      clkOn_d = cke;
      pwr_d = pwr_q;
      rdBurst_d = rdBurst_q;
      wrBurst_d = wrBurst_q;
      ap_d = ap_q;
      cl3_d = cl3_q;
      cnt_d = cnt_q;
      blenM1_d = blenM1_q;
      col_d = col_q;
      bank_d = bank_q;
      bankOpen_d = bankOpen_q;
      openRow_d = openRow_q;
      arrAddr_d = arrAddr_q;
      arrRd_d = arrRd_q;
      arrWr_d = 1'b0;
      arrByteEn_d = arrByteEn_q;
      arrWrData_d = arrWrData_q;
      arrRefresh_d = 1'b0;
      arrClear_d = 1'b0;
      if (actv) begin
         arrRd_d = 1'b0;
         if (rdBurst_q || wrBurst_q) begin
            if (cnt_q == 4'h0) begin
               rdBurst_d = 1'b0;
               wrBurst_d = 1'b0;
               if (ap_q) begin
                  bankOpen_d[bank_q] = 1'b0;
               end
            end else begin
               cnt_d = cnt_q - 4'h1;
               col_d = col_q + 9'h1;
               arrAddr_d = '{bank_q, openRow_q[bank_q], col_d};
               arrRd_d = rdBurst_q;
               arrWr_d = wrBurst_q;
               arrByteEn_d = ~dqm;
               arrWrData_d = dqIn;
            end
         end
         unique case (cmd)
            CMD_ACT: begin
               bankOpen_d[pins.ba] = 1'b1;
               openRow_d[pins.ba] = pins.addr;
            end
            CMD_RD, CMD_WR: begin
               // a new column command cuts any burst short, every clock if need be
               rdBurst_d = (cmd == CMD_RD);
               wrBurst_d = (cmd == CMD_WR);
               ap_d = pins.addr[AP_BIT];
               bank_d = pins.ba;
               col_d = pins.addr[COL_W-1:0];
               cnt_d = blenM1_q;
               arrAddr_d = '{pins.ba, openRow_q[pins.ba], pins.addr[COL_W-1:0]};
               arrRd_d = (cmd == CMD_RD);
               arrWr_d = (cmd == CMD_WR);
               arrByteEn_d = ~dqm;
               arrWrData_d = dqIn;
            end
            CMD_PRE: begin
               for (int b = 0; b < BANK_N; b++) begin
                  if (pins.addr[AP_BIT] || pins.ba == 2'(b)) begin
                     bankOpen_d[b] = 1'b0;
                  end
               end
               // words already fetched still drain, so outputs float after the latency
               if (pins.addr[AP_BIT] || pins.ba == bank_q) begin
                  rdBurst_d = 1'b0;
                  wrBurst_d = 1'b0;
                  arrRd_d = 1'b0;
                  arrWr_d = 1'b0;
               end
            end
            CMD_BST: begin
               if (cke) begin
                  rdBurst_d = 1'b0;
                  wrBurst_d = 1'b0;
                  arrRd_d = 1'b0;
                  arrWr_d = 1'b0;
               end else if (bankOpen_q == '0 && !rdBurst_q && !wrBurst_q) begin
                  pwr_d = ST_DEEP;
               end
            end
            CMD_REF: begin
               if (cke) begin
                  arrRefresh_d = 1'b1;
               end else begin
                  pwr_d = ST_SELFREF;
               end
            end
            CMD_MRS: begin
               cl3_d = (pins.addr[CL_LSB +: 3] == CL3_CODE);
               blenM1_d = (4'h1 << pins.addr[1:0]) - 4'h1;
            end
            CMD_NOP: begin
               // with a burst running, cke low only suspends the clock
               if (!cke && !rdBurst_q && !wrBurst_q) begin
                  pwr_d = ST_PDOWN;
               end
            end
         endcase
      end else begin
         unique case (pwr_q)
            ST_RUN: begin
               // suspended: read request held so the fetch is replayed on resume
            end
            ST_PDOWN, ST_SELFREF: begin
               if (cke) begin
                  pwr_d = ST_RUN;
               end
            end
            ST_DEEP: begin
               if (cke) begin
                  pwr_d = ST_RUN;
                  arrClear_d = 1'b1;
                  bankOpen_d = '0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         clkOn_q <= 1'b0;
         pwr_q <= ST_RUN;
         rdBurst_q <= 1'b0;
         wrBurst_q <= 1'b0;
         ap_q <= 1'b0;
         cl3_q <= CL3_RST;
         cnt_q <= 4'h0;
         blenM1_q <= BLEN_M1_RST;
         col_q <= '0;
         bank_q <= 2'h0;
         bankOpen_q <= '0;
         openRow_q <= '{default: '0};
         arrAddr_q <= '0;
         arrRd_q <= 1'b0;
         arrWr_q <= 1'b0;
         arrByteEn_q <= '0;
         arrWrData_q <= '0;
         arrRefresh_q <= 1'b0;
         arrClear_q <= 1'b0;
      end else begin
         clkOn_q <= clkOn_d;
         pwr_q <= pwr_d;
         rdBurst_q <= rdBurst_d;
         wrBurst_q <= wrBurst_d;
         ap_q <= ap_d;
         cl3_q <= cl3_d;
         cnt_q <= cnt_d;
         blenM1_q <= blenM1_d;
         col_q <= col_d;
         bank_q <= bank_d;
         bankOpen_q <= bankOpen_d;
         openRow_q <= openRow_d;
         arrAddr_q <= arrAddr_d;
         arrRd_q <= arrRd_d;
         arrWr_q <= arrWr_d;
         arrByteEn_q <= arrByteEn_d;
         arrWrData_q <= arrWrData_d;
         arrRefresh_q <= arrRefresh_d;
         arrClear_q <= arrClear_d;
      end
   end

   // read pipe: one extra stage at latency three; frozen while the clock is suspended
   always_comb begin
      p0Data_d = p0Data_q;
      p0Val_d = p0Val_q;
      dqmD1_d = dqmD1_q;
      dqOut_d = dqOut_q;
      dqOe_d = dqOe_q;
      if (clkOn_q) begin
         p0Data_d = rdData;
         p0Val_d = arrRd_q;
         dqmD1_d = dqm;
         dqOut_d = cl3_q ? p0Data_q : rdData;
         dqOe_d = {MASK_W{cl3_q ? p0Val_q : arrRd_q}} & ~dqmD1_q;
      end
      if (pwr_q == ST_DEEP) begin
         dqOe_d = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         p0Data_q <= '0;
         p0Val_q <= 1'b0;
         dqmD1_q <= '0;
         dqOut_q <= '0;
         dqOe_q <= '0;
      end else begin
         p0Data_q <= p0Data_d;
         p0Val_q <= p0Val_d;
         dqmD1_q <= dqmD1_d;
         dqOut_q <= dqOut_d;
         dqOe_q <= dqOe_d;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence rdTwice_s;
      (actv && cmd == CMD_RD) ##1 (actv && cmd == CMD_RD);
   endsequence
   sequence preRd_s;
      actv && rdBurst_q && cmd == CMD_PRE && (pins.addr[AP_BIT] || pins.ba == bank_q);
   endsequence

   rd_back2back_a:
      assert property (rdTwice_s |-> arrRd_q ##1 arrRd_q) else $error("back to back read lost");
   rd_dqm_a:
      assert property (clkOn_q ##1 clkOn_q |=> (dqOe_q & $past(dqm, 2)) == '0)
         else $error("read mask did not float byte after two clocks");
   wr_mask_a:
      assert property ((actv && cmd == CMD_WR) |=> arrWr_q && arrByteEn_q == ~$past(dqm)
         && arrWrData_q == $past(dqIn)) else $error("write mask or data not same cycle");
   pre_hiz3_a:
      assert property ((cl3_q ##0 preRd_s) ##1 (clkOn_q && cmd != CMD_RD)[*2] |=> dqOe_q == '0)
         else $error("outputs still driven three clocks after precharge");
   pre_hiz2_a:
      assert property ((!cl3_q ##0 preRd_s) ##1 (clkOn_q && cmd != CMD_RD) |=> dqOe_q == '0)
         else $error("outputs still driven two clocks after precharge");
   cke_off_a:
      assert property ((!cke && pwr_q == ST_RUN) |-> ##2 ($stable(arrAddr_q) && !arrWr_q))
         else $error("internal clock not suspended one clock after cke low");
   cke_on_a:
      assert property ((!clkOn_q && cke && pwr_q == ST_RUN) ##1 (cmd == CMD_WR) |=> arrWr_q)
         else $error("write not taken one clock after cke high");
   deep_exit_a:
      assert property ((pwr_q == ST_DEEP && cke) |=> pwr_q == ST_RUN && arrClear_q
         && bankOpen_q == '0) else $error("deep power down exit wrong");
   deep_entry_a:
      assert property ((actv && !cke && cmd == CMD_BST && bankOpen_q == '0 && !rdBurst_q
         && !wrBurst_q) |=> pwr_q == ST_DEEP) else $error("deep power down not entered");
endmodule // sdram_timing_core
`default_nettype wire

// *** testbench/ctrl_model.sv ***
// ctrl_model: memory controller model that drives commands into the sdram timing core
`timescale 1ns/10ps
`default_nettype none
module ctrl_model
   import sdram_timing_pkg::*;
(
   input wire logic clk_sys,
   output logic cke,
   output var cmd_pins_type pins,
   output logic [MASK_W-1:0] dqm,
   output logic [DATA_W-1:0] dqIn
);
   initial begin
      cke = 1'b1;
      pins = '{1'b0, 1'b1, 1'b1, 1'b1, 2'h0, '0};
      dqm = '0;
      dqIn = '0;
   end
   // one command per edge; callers pad with nops to cover the ns spacings
   // clock never stretched, only cke throttles; run is far shorter than the refresh period
   task automatic issue(input cmd_type c, input logic ck, input logic [1:0] b,
         input logic [ROW_W-1:0] a, input logic [MASK_W-1:0] m, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      cke <= ck; // deep entry is a burst stop with cke low, all banks closed and no burst running; exit is cke high
      pins <= '{1'b0, c[2], c[1], c[0], b, a};
      dqm <= m;
      dqIn <= d; // write word rides with its command; a fresh value every edge
   endtask
endmodule // ctrl_model
`default_nettype wire

// *** testbench/tb.sv ***
// tb: self-checking bench comparing the sdram timing core with a reference model
`timescale 1ns/10ps
`default_nettype none
module tb;
   import sdram_timing_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic cke, arrRd_q, arrWr_q, arrRefresh_q, arrClear_q;
   logic eRd, eWr, eRef, eClr, ckeP, isRd;
   logic [1:0] bk, pipeV;
   cmd_pins_type pins;
   logic [MASK_W-1:0] dqm, dqOe_q, arrByteEn_q, eOe, eBe, dqmP;
   logic [DATA_W-1:0] dqIn, dqOut_q, arrWrData_q, eOut, eWd;
   arr_addr_type arrAddr_q, eAddr, curA;
   arr_addr_type pipeA[2];
   pwr_type pwr_q, pw;
   cmd_type c;
   cmd_type pc[3] = '{CMD_NOP, CMD_REF, CMD_BST};
   int n_mismatch = 0;
   int comparisons = 0;
   int cl, bl, left;
   // array answers with a word derived from its address so every fetch is traceable
   wire logic [DATA_W-1:0] rdData = {arrAddr_q, 8'h3c};

   always #10 clk_sys = ~clk_sys;

   ctrl_model ctrl_model_inst (.clk_sys(clk_sys), .cke(cke), .pins(pins), .dqm(dqm), .dqIn(dqIn));
   sdram_timing_core sdram_timing_core_inst (.clk_sys(clk_sys), .rst_b(rst_b), .cke(cke),
      .pins(pins), .dqm(dqm), .dqIn(dqIn), .rdData(rdData), .dqOut_q(dqOut_q), .dqOe_q(dqOe_q),
      .arrAddr_q(arrAddr_q), .arrRd_q(arrRd_q), .arrWr_q(arrWr_q), .arrByteEn_q(arrByteEn_q),
      .arrWrData_q(arrWrData_q), .arrRefresh_q(arrRefresh_q), .arrClear_q(arrClear_q),
      .pwr_q(pwr_q));

   // reference model; reads inputs before the edge's non-blocking updates land
   always @(posedge clk_sys) begin
      c = pins.csN ? CMD_NOP : cmd_type'({pins.rasN, pins.casN, pins.weN});
      // a suspended clock holds the read fetch, so eRd is cleared only where it moves
      {eWr, eRef, eClr} = 3'h0;
      if (!rst_b) begin
         eRd = 1'b0;
         dqmP = '0;
         left = 0;
         cl = 3;
         bl = 1;
         pw = ST_RUN;
         pipeV = 2'h0;
         eOe = '0;
      end else if (pw != ST_RUN) begin
         eRd = 1'b0;
         if (cke) begin
            eClr = (pw == ST_DEEP);
            pw = ST_RUN;
         end
      end else if (ckeP) begin
         if (c inside {CMD_RD, CMD_WR, CMD_PRE, CMD_BST})
            left = 0;
         case (c)
            CMD_MRS: begin
               bl = 1 << pins.addr[1:0];
               cl = (pins.addr[6:4] == CL3_CODE) ? 3 : 2;
            end
            CMD_ACT: curA.row = pins.addr;
            CMD_REF: eRef = cke;
            CMD_RD, CMD_WR: begin
               left = bl;
               isRd = (c == CMD_RD);
               curA.bank = pins.ba;
               curA.col = pins.addr[COL_W-1:0];
            end
            default: ;
         endcase
         if (!cke && left == 0) begin
            if (c == CMD_NOP)
               pw = ST_PDOWN;
            if (c == CMD_REF)
               pw = ST_SELFREF;
            if (c == CMD_BST)
               pw = ST_DEEP;
         end
         eOe = pipeV[cl-2] ? ~dqmP : '0;
         eOut = {pipeA[cl-2], 8'h3c};
         pipeA[1] = pipeA[0];
         pipeA[0] = curA;
         pipeV = {pipeV[0], (left > 0) && isRd};
         eAddr = curA;
         eRd = pipeV[0];
         eWr = (left > 0) && !isRd;
         eWd = dqIn;
         eBe = ~dqm;
         if (left > 0) begin
            left--;
            curA.col++;
         end
         dqmP = dqm; // mask pipe only moves on live clocks
      end
      ckeP = cke & rst_b;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   always @(negedge clk_sys) begin
      chk("pwr", 32'(pw), 32'(pwr_q));
      chk("rd", 32'(eRd), 32'(arrRd_q));
      chk("wr", 32'(eWr), 32'(arrWr_q));
      chk("refresh", 32'(eRef), 32'(arrRefresh_q));
      chk("clear", 32'(eClr), 32'(arrClear_q));
      chk("oe", 32'(eOe), 32'(dqOe_q));
      if (eRd | eWr) chk("addr", 32'(eAddr), 32'(arrAddr_q));
      if (eWr) chk("wdata", eWd, arrWrData_q);
      if (eWr) chk("ben", 32'(eBe), 32'(arrByteEn_q));
      if (|eOe) chk("dout", eOut, dqOut_q);
   end

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // random mask and data on every edge, so masks land mid-burst too
   task automatic op(input cmd_type cc, input logic [ROW_W-1:0] a, input logic k = 1'b1);
      ctrl_model_inst.issue(cc, k, bk, a, MASK_W'($urandom), $urandom);
   endtask

   task automatic idle(input int n, input logic k = 1'b1);
      repeat (n) op(CMD_NOP, '0, k);
   endtask

   initial begin
      void'($urandom(33));
      bk = 2'h0;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      idle(2);
      for (int k = 2; k <= 3; k++) begin
         bk = 2'($urandom);
         op(CMD_MRS, k == 3 ? 13'h032 : 13'h023); // burst of 8, then 4
         idle(2);
         op(CMD_ACT, 13'($urandom));
         idle(1);
         op(CMD_WR, 13'($urandom % 500));
         op(CMD_NOP, '0, 1'b0); // cke low mid-burst only suspends
         idle(2, 1'b0);
         idle(1);
         op(CMD_WR, 13'($urandom % 500)); // taken on the first live clock
         idle(3);
         op(CMD_RD, 13'($urandom % 500));
         op(CMD_RD, 13'($urandom % 500)); // cuts the first burst
         op(CMD_NOP, '0, 1'b0); // read fetch and output pipe freeze
         idle(2, 1'b0);
         idle(1);
         idle(5);
         op(CMD_RD, 13'($urandom % 500));
         op(CMD_PRE, 13'h400); // all banks, mid-burst
         idle(4);
         op(CMD_REF, '0);
         idle(4);
      end
      foreach (pc[i]) begin
         op(pc[i], '0, 1'b0);
         idle(3, 1'b0);
         idle(1);
         idle(4);
      end
      op(CMD_ACT, 13'($urandom));
      idle(1);
      op(CMD_RD, 13'h010);
      idle(6);
      give_verdict;
   end

   // cut a hang well past the hundred or so cycles the sequence needs
   initial begin
      repeat (2000) @(posedge clk_sys);
      n_mismatch++;
      give_verdict;
   end
endmodule // tb
`default_nettype wire
